// ==== include/mseq_pkg.sv ====
package mseq_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int OUT_W   = 8;
  localparam int COND_W  = 8;
  localparam int OP_W    = 4;
  localparam int DEPTH   = 256;
  localparam int STACK_D = 8;
  localparam int SP_W    = 3;
  localparam int WAYS    = 4;
  localparam int WAY_W   = 2;
  // ==========================================================
  // addresses and reset values
  localparam logic [ADDR_W-1:0] BOOT_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
  localparam logic [SP_W-1:0]   SP_ZERO   = 3'h0;
  localparam logic [SP_W-1:0]   SP_ONE    = 3'h1;
  localparam logic [1:0]        RST_HOLD  = 2'h3;
  localparam logic [1:0]        CNT_ZERO  = 2'h0;
  localparam logic [1:0]        CNT_ONE   = 2'h1;
  // ==========================================================
  // instruction types, thirteen of them
  typedef enum logic [OP_W-1:0] {
    OP_CONTINUE  = 4'h0,
    OP_JUMP      = 4'h1,
    OP_CALL      = 4'h2,
    OP_RETURN    = 4'h3,
    OP_LOADC     = 4'h4,
    OP_LOOPNZ    = 4'h5,
    OP_DECNZ     = 4'h6,
    OP_PUSHLOADC = 4'h7,
    OP_POPC      = 4'h8,
    OP_PUSH      = 4'h9,
    OP_PUSHI     = 4'ha,
    OP_ANDPUSHI  = 4'hb,
    OP_POPXORC   = 4'hc
  } op_t;
  // program mode states
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_START = 3'b010,
    ST_RUN   = 3'b100
  } seq_state_t;
endpackage

// ==== verilog/mseq_branch_select.sv ====
`timescale 1ns/100ps
// ==========================================================
// branch select: user functions of the conditions pick a way
module mseq_branch_select (
  // conditions and programmed functions
  input  wire logic [7:0]  cond_in,
  input  wire logic [31:0] care_in,
  input  wire logic [31:0] match_in,
  // result
  output logic [1:0]       way_out
);
  logic [3:0] hit;
  // one masked compare per way
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_way
      assign hit[g] = ((cond_in ^ match_in[g*8 +: 8]) & care_in[g*8 +: 8]) == 8'h00;
    end
  endgenerate
  // priority like an if / elseif chain, last way is the else
  always_comb begin
    if (hit[0]) begin
      way_out = 2'h0;
    end else if (hit[1]) begin
      way_out = 2'h1;
    end else if (hit[2]) begin
      way_out = 2'h2;
    end else begin
      way_out = 2'h3;
    end
  end
endmodule

// ==== verilog/mseq_core.sv ====
`timescale 1ns/100ps
module mseq_core (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // pins
  input  wire logic        sequencer_reset_low_in,
  input  wire logic [7:0]  condition_inputs_in,
  // programming port
  input  wire logic        prog_we_in,
  input  wire logic        prog_erase_in,
  input  wire logic        prog_lock_in,
  input  wire logic [7:0]  prog_addr_in,
  input  wire logic [1:0]  prog_way_in,
  input  wire logic [31:0] prog_word_in,
  input  wire logic        prog_multi_in,
  input  wire logic [31:0] prog_care_in,
  input  wire logic [31:0] prog_match_in,
  input  wire logic        read_req_in,
  // outputs
  output logic [7:0]       pattern_out,
  output logic [7:0]       addr_out,
  output logic [31:0]      read_data_out,
  output logic             read_valid_out,
  output logic             lock_out
);
  // word: [31:28] op, [27:20] out, [19:12] target, [11:4] const/return
  logic [31:0] mem_reg [256][4];
  logic [255:0] multi_reg;
  logic [31:0] care_reg [256];
  logic [31:0] match_reg [256];
  logic        lock_reg;
  logic [7:0]  cnt_reg;
  logic [7:0]  stk_reg [8];
  logic [2:0]  sp_reg;
  logic [7:0]  pc_reg;
  logic [31:0] pipe_reg;
  logic [1:0]  rcnt_reg;
  logic        rst_long_reg;
  logic        r_meta_reg, r_sync_reg;
  logic [7:0]  c_meta_reg, c_sync_reg;
  mseq_pkg::seq_state_t st_reg;
  // ==========================================================
  // pin synchronisers
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      r_meta_reg <= 1'b0;
      r_sync_reg <= 1'b0;
      c_meta_reg <= 8'h00;
      c_sync_reg <= 8'h00;
    end else begin
      r_meta_reg <= sequencer_reset_low_in;
      r_sync_reg <= r_meta_reg;
      c_meta_reg <= condition_inputs_in;
      c_sync_reg <= c_meta_reg;
    end
  end
  // ==========================================================
  // next address decode
  logic [1:0]  way;
  logic [7:0]  nxt_addr;
  logic [31:0] sel_word;
  logic [3:0]  op;
  logic [7:0]  tgt, kon, top;
  assign op  = pipe_reg[31:28];
  assign tgt = pipe_reg[19:12];
  assign kon = pipe_reg[11:4];
  assign top = stk_reg[sp_reg - mseq_pkg::SP_ONE];
  always_comb begin
    nxt_addr = tgt;
    unique case (op)
      mseq_pkg::OP_RETURN: nxt_addr = top;
      mseq_pkg::OP_LOOPNZ: nxt_addr = (cnt_reg == 8'h00) ? tgt : kon;
      default:             nxt_addr = tgt;
    endcase
  end
  // conditions are those synchronised values present at the load edge
  mseq_branch_select u_sel (
    .cond_in  (c_sync_reg),
    .care_in  (care_reg[nxt_addr]),
    .match_in (match_reg[nxt_addr]),
    .way_out  (way)
  );
  // single-way locations always use word 0
  assign sel_word = multi_reg[nxt_addr] ? mem_reg[nxt_addr][way]
                                        : mem_reg[nxt_addr][0];
  // ==========================================================
  // reset hold: long low reset shows boot word till fourth clock after release is seen
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rcnt_reg     <= mseq_pkg::CNT_ZERO;
      rst_long_reg <= 1'b0;
      st_reg       <= mseq_pkg::ST_RESET;
    end else if (!r_sync_reg) begin
      st_reg <= mseq_pkg::ST_RESET;
      if (rcnt_reg != mseq_pkg::RST_HOLD) begin
        rcnt_reg <= rcnt_reg + mseq_pkg::CNT_ONE;
      end else begin
        rst_long_reg <= 1'b1;
      end
    end else begin
      unique case (st_reg)
        mseq_pkg::ST_RESET: begin
          st_reg   <= mseq_pkg::ST_START;
          rcnt_reg <= mseq_pkg::CNT_ONE;
        end
        mseq_pkg::ST_START: begin
          if (rcnt_reg == mseq_pkg::RST_HOLD) begin
            st_reg       <= mseq_pkg::ST_RUN;
            rst_long_reg <= 1'b0;
          end else begin
            rcnt_reg <= rcnt_reg + mseq_pkg::CNT_ONE;
          end
        end
        mseq_pkg::ST_RUN: rcnt_reg <= mseq_pkg::CNT_ZERO;
        default: st_reg <= mseq_pkg::ST_RESET;
      endcase
    end
  end
  wire running = (st_reg == mseq_pkg::ST_RUN);
  // ==========================================================
  // pipeline, counter and stack
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pipe_reg <= 32'h0000_0000;
      pc_reg   <= mseq_pkg::BOOT_ADDR;
      cnt_reg  <= mseq_pkg::ZERO_DATA;
      sp_reg   <= mseq_pkg::SP_ZERO;
    end else if (!running) begin
      pipe_reg <= mem_reg[mseq_pkg::BOOT_ADDR][0];
      pc_reg   <= mseq_pkg::BOOT_ADDR;
      sp_reg   <= mseq_pkg::SP_ZERO;
    end else begin
      pipe_reg <= sel_word;
      pc_reg   <= nxt_addr;
      unique case (op)
        mseq_pkg::OP_CALL: begin
          stk_reg[sp_reg] <= (kon == mseq_pkg::ZERO_DATA) ?
                             pc_reg + mseq_pkg::ADDR_ONE : kon;
          sp_reg <= sp_reg + mseq_pkg::SP_ONE;
        end
        mseq_pkg::OP_RETURN: sp_reg <= sp_reg - mseq_pkg::SP_ONE;
        mseq_pkg::OP_LOADC:  cnt_reg <= kon;
        mseq_pkg::OP_LOOPNZ, mseq_pkg::OP_DECNZ: begin
          if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
        end
        mseq_pkg::OP_PUSHLOADC: begin
          stk_reg[sp_reg] <= cnt_reg;
          sp_reg  <= sp_reg + mseq_pkg::SP_ONE;
          cnt_reg <= kon;
        end
        mseq_pkg::OP_POPC: begin
          cnt_reg <= top;
          sp_reg  <= sp_reg - mseq_pkg::SP_ONE;
        end
        mseq_pkg::OP_PUSH: begin
          stk_reg[sp_reg] <= kon;
          sp_reg <= sp_reg + mseq_pkg::SP_ONE;
        end
        mseq_pkg::OP_PUSHI: begin
          stk_reg[sp_reg] <= c_sync_reg;
          sp_reg <= sp_reg + mseq_pkg::SP_ONE;
        end
        mseq_pkg::OP_ANDPUSHI: begin
          stk_reg[sp_reg] <= c_sync_reg & kon;
          sp_reg <= sp_reg + mseq_pkg::SP_ONE;
        end
        mseq_pkg::OP_POPXORC: begin
          cnt_reg <= top ^ kon;
          sp_reg  <= sp_reg - mseq_pkg::SP_ONE;
        end
        default: ;
      endcase
    end
  end
  // ==========================================================
  // program store: erase wipes words, branch functions and lock
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      lock_reg <= 1'b0;
    end else if (prog_erase_in) begin
      lock_reg  <= 1'b0;
      multi_reg <= '0;
      for (int a = 0; a < 256; a++) begin
        care_reg[a]  <= 32'h0000_0000;
        match_reg[a] <= 32'h0000_0000;
        for (int w = 0; w < 4; w++) mem_reg[a][w] <= 32'h0000_0000;
      end
    end else begin
      if (prog_lock_in) lock_reg <= 1'b1;
      if (prog_we_in && !lock_reg) begin // locked part is no longer writable
        mem_reg[prog_addr_in][prog_way_in] <= prog_word_in;
        multi_reg[prog_addr_in] <= prog_multi_in;
        care_reg[prog_addr_in]  <= prog_care_in;
        match_reg[prog_addr_in] <= prog_match_in;
      end
    end
  end
  // ==========================================================
  // readback port and pin outputs
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      read_data_out  <= 32'h0000_0000;
      read_valid_out <= 1'b0;
      pattern_out    <= mseq_pkg::ZERO_DATA;
      addr_out       <= mseq_pkg::BOOT_ADDR;
      lock_out       <= 1'b0;
    end else begin
      read_valid_out <= read_req_in && !lock_reg;
      read_data_out  <= (read_req_in && !lock_reg) ? mem_reg[prog_addr_in][prog_way_in]
                                                   : 32'h0000_0000;
      pattern_out    <= (rst_long_reg || !running) ? mem_reg[mseq_pkg::BOOT_ADDR][0][27:20]
                                                   : pipe_reg[27:20];
      addr_out       <= pc_reg;
      lock_out       <= lock_reg;
    end
  end
  // ==========================================================
  // checks
  chk_lock_blocks_read: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $past(lock_reg) |-> !read_valid_out && read_data_out == 32'h0000_0000)
    else $error("readback while locked");
  chk_erase_clears_lock: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    prog_erase_in |=> !lock_reg)
    else $error("lock survived erase");
  chk_jump_target: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    running && r_sync_reg && op == mseq_pkg::OP_JUMP |=> pc_reg == $past(tgt))
    else $error("jump missed target");
  chk_call_push: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    running && r_sync_reg && op == mseq_pkg::OP_CALL && sp_reg != 3'h7
    |=> sp_reg == $past(sp_reg) + 3'h1 && pc_reg == $past(tgt))
    else $error("call did not push");
  // boot word must stay put for three samples once the pin is seen high
  sequence boot_held;
    !running ##1 !running ##1 !running;
  endsequence
  chk_reset_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $rose(r_sync_reg) |-> boot_held)
    else $error("boot word left early");
  chk_boot_addr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !running |=> pc_reg == mseq_pkg::BOOT_ADDR)
    else $error("boot address not held");
endmodule

// ==== bench/cond_source.sv ====
`timescale 1ns/100ps
// ==========================================================
// far side: system logic that drives the condition pins
module cond_source (
  // clock
  input  wire logic       ref_clk_in,
  // requested condition value
  input  wire logic [7:0] cond_value_in,
  // condition pins
  output logic [7:0]      cond_out
);
  // pins change only on the falling edge, clear of the rising sampling edge
  always @(negedge ref_clk_in) begin
    cond_out <= cond_value_in;
  end
endmodule

// ==== bench/tb_microsequencer_multiway_branch.sv ====
`timescale 1ns/100ps
module tb_microsequencer_multiway_branch;
  logic        clk, rst, pin_rst_low, we, erase, lock, multi, rreq;
  logic [7:0]  cond_value, cond, paddr, pat, addr;
  logic [1:0]  pway;
  logic [31:0] pword, rdata;
  logic        rvalid, locked;
  int          num_errors, total_checks, i;
  logic [7:0]  c;
  // ==========================================================
  // clock and parts
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  cond_source cond_source_inst (.ref_clk_in(clk), .cond_value_in(cond_value), .cond_out(cond));
  mseq_core mseq_core_inst (
    .ref_clk_in(clk), .sys_rst_in(rst), .sequencer_reset_low_in(pin_rst_low),
    .condition_inputs_in(cond), .prog_we_in(we), .prog_erase_in(erase),
    .prog_lock_in(lock), .prog_addr_in(paddr), .prog_way_in(pway),
    .prog_word_in(pword), .prog_multi_in(multi), .prog_care_in(32'h0303_0303),
    .prog_match_in(32'h0002_0100), .read_req_in(rreq), .pattern_out(pat),
    .addr_out(addr), .read_data_out(rdata), .read_valid_out(rvalid), .lock_out(locked));
  // ==========================================================
  // helpers
  function automatic logic [31:0] mk(mseq_pkg::op_t op, logic [7:0] p, logic [7:0] t);
    return {op, p, t, 8'h00, 4'h0};
  endfunction
  // ways match cond[1:0] = 0,1,2 in order; anything else falls to way 3
  function automatic logic [1:0] exp_way(logic [7:0] cv);
    return cv[1:0];
  endfunction
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic prog(input logic [7:0] a, input logic [1:0] w, input logic [31:0] d,
                      input logic m);
    paddr = a;
    pway = w;
    pword = d;
    multi = m;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    @(negedge clk);
  endtask
  // one-cycle read request, answer sampled in the following cycle
  task automatic rd(input logic [7:0] a, input logic [1:0] w, input logic v,
                    input logic [31:0] d);
    paddr = a;
    pway = w;
    rreq = 1'b1;
    @(negedge clk);
    rreq = 1'b0;
    check("read_valid", rvalid, v);
    check("read_data", rdata, d);
  endtask
  // bounded wait; running out ends the run as a failure
  task automatic wait_addr(input logic [7:0] a);
    int n;
    for (n = 0; n < 200 && addr !== a; n++) @(negedge clk);
    if (addr !== a) begin
      check("wait_addr", addr, a);
      complete_run();
    end
  endtask
  function automatic logic [7:0] way_target(logic [1:0] w);
    return (w == 2'h0) ? 8'h20 : 8'h30 + 8'h10 * w;
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    {rst, pin_rst_low, we, erase, lock, multi, rreq} = 7'b1000000;
    {cond_value, paddr, pway, pword, num_errors, total_checks} = '0;
    void'($urandom(32'hfbdff22c));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // program loop: boot calls into a four-way block, stack wraps harmlessly
    prog(8'h00, 2'h0, mk(mseq_pkg::OP_CALL, 8'ha5, 8'h10), 1'b0);
    prog(8'h10, 2'h0, mk(mseq_pkg::OP_CALL, 8'h50, 8'h20), 1'b1);
    for (i = 1; i < 4; i++) begin
      prog(8'h10, i[1:0], mk(mseq_pkg::OP_JUMP, 8'h50 + i[7:0], way_target(i[1:0])), 1'b1);
      prog(way_target(i[1:0]), 2'h0, mk(mseq_pkg::OP_JUMP, 8'h60, 8'h00), 1'b0);
    end
    prog(8'h20, 2'h0, mk(mseq_pkg::OP_RETURN, 8'h61, 8'h00), 1'b0);
    prog(8'h11, 2'h0, mk(mseq_pkg::OP_JUMP, 8'h62, 8'h00), 1'b0);
    // long pin reset shows the boot word until after release
    repeat (6) @(negedge clk);
    check("boot_pattern", pat, 32'h0000_00a5);
    check("boot_addr", addr, 32'h0000_0000);
    pin_rst_low = 1'b1;
    repeat (4) @(negedge clk);
    check("boot_hold", pat, 32'h0000_00a5);
    // random upper bits must be masked off by the care field
    for (i = 0; i < 12; i++) begin
      c = {6'($urandom_range(63)), i[1:0]};
      cond_value = c;
      repeat (4) @(negedge clk);
      wait_addr(8'h00);
      wait_addr(8'h10);
      check("way_pattern", pat, 8'h50 + exp_way(c));
      @(negedge clk);
      check("way_next", addr, way_target(exp_way(c)));
      if (exp_way(c) == 2'h0) begin
        @(negedge clk);
        check("return_addr", addr, 32'h0000_0011);
      end
    end
    // second long pin reset in mid-run
    pin_rst_low = 1'b0;
    repeat (8) @(negedge clk);
    check("reboot_pattern", pat, 32'h0000_00a5);
    check("reboot_addr", addr, 32'h0000_0000);
    pin_rst_low = 1'b1;
    wait_addr(8'h10);
    // readback, lock, then erase
    rd(8'h10, 2'h1, 1'b1, mk(mseq_pkg::OP_JUMP, 8'h51, way_target(2'h1)));
    lock = 1'b1;
    @(negedge clk);
    lock = 1'b0;
    @(negedge clk);
    check("lock_set", locked, 1'b1);
    rd(8'h10, 2'h1, 1'b0, 32'h0000_0000);
    erase = 1'b1;
    @(negedge clk);
    erase = 1'b0;
    @(negedge clk);
    check("lock_clear", locked, 1'b0);
    rd(8'h10, 2'h1, 1'b1, 32'h0000_0000);
    complete_run();
  end
endmodule
